// ===== rtl/ddr_cmd_ctrl.sv
/*
 * Controller side of a DDR memory command bus: turns user requests into
 * strobe, bank, address and clock enable patterns, tracks mode loads,
 * DLL state and self refresh, and drives the write mask.
 * Assumes the memory samples all outputs on the controller clock edge.
 */
`timescale 1ns/1ns
`include "ddr_cmd_cfg.svh"

module ddr_cmd_ctrl (
   input  wire logic                     i_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_req_valid,
   input  wire ddr_cmd_pkg::req_type     i_req_cmd,
   input  wire logic [1:0]               i_req_bank,
   input  wire logic [`ADDR_W-1:0]       i_req_addr,
   input  wire logic                     i_req_auto_pre,
   input  wire logic                     i_req_all_banks,
   input  wire logic [`BURST_FIELD_W-1:0] i_burst_cfg,
   input  wire logic                     i_dll_reset,
   input  wire logic                     i_dll_disable,
   input  wire logic                     i_drive_strength_select,
   input  wire logic [7:0]               i_wr_mask,
   output logic                          o_req_ready,
   output logic                          o_req_error,
   output logic                          o_cs_n,
   output logic                          o_ras_n,
   output logic                          o_cas_n,
   output logic                          o_we_n,
   output logic [1:0]                    o_ba,
   output logic [`ADDR_W-1:0]            o_addr,
   output logic                          o_cke,
   output logic [7:0]                    o_dm,
   output logic                          o_dll_enabled,
   output logic                          o_read_allowed,
   output logic                          o_self_refresh,
   output logic                          o_dll_reset_pending
);
   ddr_cmd_pkg::state_type state_q;
   ddr_cmd_pkg::state_type state_d;
   logic                   take;
   logic                   bad;
   logic                   wait_load;
   logic [`WAIT_W-1:0]     wait_value;
   logic                   wait_done;
   logic                   dll_load;
   logic [7:0]             dll_cnt_q;
   logic                   dll_en_q;
   logic                   reset_need_q;
   logic                   normal_need_q;
   logic                   last_rd_ap_q;
   logic                   burst_rd_q;
   logic [3:0]             code;
   logic [1:0]             bank;
   logic [`ADDR_W-1:0]     addr;

   // =========================================
   // request acceptance
   assign o_req_ready = (state_q == ddr_cmd_pkg::ST_READY) ||
                        (state_q == ddr_cmd_pkg::ST_SELF);

   always_comb begin
      bad = 1'b0;
      if (state_q == ddr_cmd_pkg::ST_SELF) begin
         bad = (i_req_cmd != ddr_cmd_pkg::REQ_SELF_EXIT);
      end else begin
         case (i_req_cmd)
            ddr_cmd_pkg::REQ_READ:       bad = !o_read_allowed;
            ddr_cmd_pkg::REQ_TERMINATE:  bad = !burst_rd_q || last_rd_ap_q;
            ddr_cmd_pkg::REQ_SELF_EXIT:  bad = 1'b1;
            default:                     bad = 1'b0;
         endcase
      end
   end

   assign take        = i_req_valid && o_req_ready && !bad;
   assign o_req_error = i_req_valid && o_req_ready && bad;

   // =========================================
   // command encoding
   always_comb begin
      code = `CMD_NOP;
      bank = i_req_bank;
      addr = i_req_addr;
      case (i_req_cmd)
         ddr_cmd_pkg::REQ_ACTIVE:     code = `CMD_ACTIVE;
         ddr_cmd_pkg::REQ_READ: begin
            code = `CMD_READ;
            addr[`AP_BIT] = i_req_auto_pre;
         end
         ddr_cmd_pkg::REQ_WRITE: begin
            code = `CMD_WRITE;
            addr[`AP_BIT] = i_req_auto_pre;
         end
         ddr_cmd_pkg::REQ_TERMINATE:  code = `CMD_TERMINATE;
         ddr_cmd_pkg::REQ_PRECHARGE: begin
            code = `CMD_PRECHARGE;
            addr[`AP_BIT] = i_req_all_banks;
         end
         ddr_cmd_pkg::REQ_REFRESH,
         ddr_cmd_pkg::REQ_SELF_ENTER: begin
            code = `CMD_REFRESH;
            addr = '0;
            bank = '0;
         end
         ddr_cmd_pkg::REQ_SELF_EXIT:  code = `CMD_NOP;
         ddr_cmd_pkg::REQ_LOAD_BASE: begin
            code = `CMD_LOAD_MODE;
            bank = `BANK_BASE_MODE;
            // operating bits zero, no reserved codes, fields
            addr = '0;
            addr[`BURST_FIELD_W-1:0] = i_burst_cfg;
            // DLL reset request, pending reset forces normal next
            addr[`DLL_RESET_BIT] = i_dll_reset && !normal_need_q;
         end
         ddr_cmd_pkg::REQ_LOAD_EXT: begin
            code = `CMD_LOAD_MODE;
            bank = `BANK_EXT_MODE;
            // DLL and drive bits, rest zero
            addr = '0;
            addr[`DLL_DIS_BIT] = i_dll_disable;
            addr[`DRIVE_BIT]   = i_drive_strength_select;
         end
         default:                     code = `CMD_NOP;
      endcase
   end

   // =========================================
   // command bus registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cs_n  <= 1'b1;
         o_ras_n <= 1'b1;
         o_cas_n <= 1'b1;
         o_we_n  <= 1'b1;
         o_ba    <= '0;
         o_addr  <= '0;
      end else if (take) begin
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= code;
         o_ba   <= bank;
         o_addr <= addr;
      end else begin
         {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_DESELECT;
      end
   end

   // clock enable low only in self refresh
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cke <= 1'b1;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_SELF_ENTER) begin
         o_cke <= 1'b0;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_SELF_EXIT) begin
         o_cke <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dm <= '0;
      end else begin
         o_dm <= i_wr_mask;
      end
   end

   // =========================================
   // controller state
   always_comb begin
      state_d = state_q;
      case (state_q)
         ddr_cmd_pkg::ST_READY: begin
            if (take && i_req_cmd == ddr_cmd_pkg::REQ_SELF_ENTER) begin
               state_d = ddr_cmd_pkg::ST_SELF;
            end else if (wait_load) begin
               state_d = ddr_cmd_pkg::ST_WAIT;
            end
         end
         ddr_cmd_pkg::ST_WAIT: begin
            if (wait_done) begin
               state_d = ddr_cmd_pkg::ST_READY;
            end
         end
         ddr_cmd_pkg::ST_SELF: begin
            if (take) begin
               state_d = ddr_cmd_pkg::ST_READY;
            end
         end
         default: state_d = ddr_cmd_pkg::ST_READY;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ddr_cmd_pkg::ST_READY;
      end else begin
         state_q <= state_d;
      end
   end

   assign wait_load  = take && (i_req_cmd == ddr_cmd_pkg::REQ_LOAD_BASE ||
                                i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT);
   assign wait_value = `WAIT_W'(`MRD_CYCLES);

   ddr_wait_counter u_mode_wait (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_load  (wait_load),
      .i_value (wait_value),
      .i_hold  (1'b0),
      .o_done  (wait_done)
   );

   // =========================================
   // DLL tracking
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dll_en_q <= 1'b1;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT) begin
         dll_en_q <= !i_dll_disable;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_SELF_EXIT) begin
         dll_en_q <= 1'b1;
      end
   end

   // DLL lock count restarts on any enable
   assign dll_load = take && ((i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT && !i_dll_disable) ||
                              i_req_cmd == ddr_cmd_pkg::REQ_SELF_EXIT ||
                              (i_req_cmd == ddr_cmd_pkg::REQ_LOAD_BASE &&
                               addr[`DLL_RESET_BIT]));

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dll_cnt_q <= 8'(`DLL_LOCK_CYCLES);
      end else if (dll_load) begin
         dll_cnt_q <= 8'(`DLL_LOCK_CYCLES);
      end else if (dll_cnt_q != '0 && o_cke) begin
         dll_cnt_q <= dll_cnt_q - 1'b1;
      end
   end

   assign o_read_allowed = dll_en_q && (dll_cnt_q == '0) && !reset_need_q;
   assign o_dll_enabled  = dll_en_q;

   // DLL enable by extended load needs base reset load, self exit does not
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         reset_need_q <= 1'b0;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT) begin
         reset_need_q <= !i_dll_disable;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_BASE &&
                   addr[`DLL_RESET_BIT]) begin
         reset_need_q <= 1'b0;
      end
   end

   // DLL reset bit not retained, normal load follows
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         normal_need_q <= 1'b0;
      end else if (take && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_BASE) begin
         normal_need_q <= addr[`DLL_RESET_BIT];
      end
   end

   assign o_dll_reset_pending = reset_need_q || normal_need_q;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         burst_rd_q   <= 1'b0;
         last_rd_ap_q <= 1'b0;
      end else if (take) begin
         case (i_req_cmd)
            ddr_cmd_pkg::REQ_READ: begin
               burst_rd_q   <= 1'b1;
               last_rd_ap_q <= i_req_auto_pre;
            end
            ddr_cmd_pkg::REQ_WRITE,
            ddr_cmd_pkg::REQ_TERMINATE,
            ddr_cmd_pkg::REQ_PRECHARGE: burst_rd_q <= 1'b0;
            default: burst_rd_q <= burst_rd_q;
         endcase
      end
   end

   assign o_self_refresh = (state_q == ddr_cmd_pkg::ST_SELF);
endmodule

// ===== rtl/ddr_cmd_cfg.svh
/*
 * Constants for the memory command controller: strobe encodings, bank
 * codes, mode bit positions and timing counts.
 * Assumes a 100 MHz controller clock.
 */
`ifndef DDR_CMD_CFG_SVH
`define DDR_CMD_CFG_SVH

// strobe codes {cs_n, ras_n, cas_n, we_n}
`define CMD_DESELECT    4'hF
`define CMD_NOP         4'h7
`define CMD_ACTIVE      4'h3
`define CMD_READ        4'h5
`define CMD_WRITE       4'h4
`define CMD_TERMINATE   4'h6
`define CMD_PRECHARGE   4'h2
`define CMD_REFRESH     4'h1
`define CMD_LOAD_MODE   4'h0

`define BANK_BASE_MODE  2'h0
`define BANK_EXT_MODE   2'h1

`define ADDR_W          13
`define AP_BIT          10
`define DLL_RESET_BIT   8
`define OPMODE_LO       7
`define BURST_FIELD_W   7
`define DLL_DIS_BIT     0
`define DRIVE_BIT       1

`define CLK_PERIOD_NS   10
`define MRD_NS          20
`define MRD_CYCLES      ((`MRD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DLL_LOCK_CYCLES 200
`define WAIT_W          8

`endif

// ===== rtl/ddr_cmd_pkg.sv
/*
 * Types for the memory command controller.
 * Assumes ddr_cmd_cfg.svh supplies the numeric constants.
 */
package ddr_cmd_pkg;
   typedef enum logic [3:0] {
      REQ_NOP        = 4'h0,
      REQ_ACTIVE     = 4'h1,
      REQ_READ       = 4'h2,
      REQ_WRITE      = 4'h3,
      REQ_TERMINATE  = 4'h4,
      REQ_PRECHARGE  = 4'h5,
      REQ_REFRESH    = 4'h6,
      REQ_SELF_ENTER = 4'h7,
      REQ_SELF_EXIT  = 4'h8,
      REQ_LOAD_BASE  = 4'h9,
      REQ_LOAD_EXT   = 4'hA
   } req_type;

   typedef enum logic [1:0] {
      ST_READY = 2'h0,
      ST_WAIT  = 2'h1,
      ST_SELF  = 2'h2
   } state_type;
endpackage

// ===== rtl/ddr_wait_counter.sv
/*
 * Down counter for the guard interval after mode loads.
 * Assumes a synchronous load pulse and the controller clock.
 */
`timescale 1ns/1ns
`include "ddr_cmd_cfg.svh"

module ddr_wait_counter (
   input  wire logic                 i_clk,
   input  wire logic                 i_rstn,
   input  wire logic                 i_load,
   input  wire logic [`WAIT_W-1:0]   i_value,
   input  wire logic                 i_hold,
   output logic                      o_done
);
   logic [`WAIT_W-1:0] count_q;

   // =========================================
   // counting
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         count_q <= '0;
      end else if (i_load) begin
         count_q <= i_value;
      end else if (count_q != '0 && !i_hold) begin
         count_q <= count_q - 1'b1;
      end
   end

   assign o_done = (count_q == '0);
endmodule

// ===== verif/ddr_cmd_ctrl_assertions.sv
/* Port checker for the memory command controller.
   Assumes a bind onto ddr_cmd_ctrl and the constants of ddr_cmd_cfg.svh. */
`timescale 1ns/1ns
`include "ddr_cmd_cfg.svh"

module ddr_cmd_ctrl_assertions (
   input wire logic                 i_clk,
   input wire logic                 i_rstn,
   input wire logic                 i_req_valid,
   input wire ddr_cmd_pkg::req_type i_req_cmd,
   input wire logic [7:0]           i_wr_mask,
   input wire logic                 o_req_ready,
   input wire logic                 o_req_error,
   input wire logic                 o_cs_n,
   input wire logic                 o_ras_n,
   input wire logic                 o_cas_n,
   input wire logic                 o_we_n,
   input wire logic [1:0]           o_ba,
   input wire logic [`ADDR_W-1:0]   o_addr,
   input wire logic                 o_cke,
   input wire logic [7:0]           o_dm,
   input wire logic                 o_read_allowed,
   input wire logic                 o_self_refresh
);
   wire logic [3:0] cmd_w = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
   wire logic       take_w = i_req_valid & o_req_ready & !o_req_error;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // ==========================================================
   // properties
   property p_read_gate;
      i_req_valid && o_req_ready && i_req_cmd == ddr_cmd_pkg::REQ_READ && !o_read_allowed
         |-> o_req_error;
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("early read taken");
   property p_idle; !take_w |=> cmd_w == `CMD_DESELECT; endproperty
   a_idle: assert property (p_idle) else $error("strobes not idle");
   property p_read; take_w && i_req_cmd == ddr_cmd_pkg::REQ_READ |=> cmd_w == `CMD_READ; endproperty
   a_read: assert property (p_read) else $error("bad read code");
   property p_write;
      take_w && i_req_cmd == ddr_cmd_pkg::REQ_WRITE |=> cmd_w == `CMD_WRITE;
   endproperty
   a_write: assert property (p_write) else $error("bad write code");
   property p_self; take_w && i_req_cmd == ddr_cmd_pkg::REQ_SELF_ENTER
      |=> cmd_w == `CMD_REFRESH && !o_cke && o_self_refresh; endproperty
   a_self: assert property (p_self) else $error("bad self entry");
   property p_cke; !o_self_refresh |-> o_cke; endproperty
   a_cke: assert property (p_cke) else $error("clock enable low");
   property p_base; take_w && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_BASE |=> cmd_w == `CMD_LOAD_MODE
      && o_ba == `BANK_BASE_MODE && o_addr[7] == 1'b0 && o_addr[12:9] == 4'h0; endproperty
   a_base: assert property (p_base) else $error("bad base load");
   property p_ext; take_w && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT |=> cmd_w == `CMD_LOAD_MODE
      && o_ba == `BANK_EXT_MODE && o_addr[12:2] == 11'h000 ##0 !o_req_ready[*3] ##1 o_req_ready;
   endproperty
   a_ext: assert property (p_ext) else $error("bad extended load");
   property p_dm; $past(i_rstn) |-> o_dm == $past(i_wr_mask); endproperty
   a_dm: assert property (p_dm) else $error("mask not forwarded");
   property p_exit; take_w && i_req_cmd == ddr_cmd_pkg::REQ_SELF_EXIT
      |=> o_cke && !o_self_refresh && !o_read_allowed; endproperty
   a_exit: assert property (p_exit) else $error("bad self exit");
   c_read: cover property (take_w && i_req_cmd == ddr_cmd_pkg::REQ_READ);
   c_ext: cover property (take_w && i_req_cmd == ddr_cmd_pkg::REQ_LOAD_EXT);
   c_refused: cover property (o_req_error);
endmodule

// ===== verif/ddr_mem_model.sv
/* Behavioural memory device on the far side of the command bus.
   Assumes strobes, bank, address, clock enable and mask from the controller. */
`timescale 1ns/1ns
`include "ddr_cmd_cfg.svh"

module ddr_mem_model (
   input  wire logic               i_clk,
   input  wire logic               i_rstn,
   input  wire logic               i_cs_n,
   input  wire logic               i_ras_n,
   input  wire logic               i_cas_n,
   input  wire logic               i_we_n,
   input  wire logic [1:0]         i_ba,
   input  wire logic [`ADDR_W-1:0] i_addr,
   input  wire logic               i_cke,
   input  wire logic [7:0]         i_dm,
   output logic [`ADDR_W-1:0]      o_mode_q,
   output logic [`ADDR_W-1:0]      o_ext_q,
   output logic [3:0]              o_cmd_q,
   output logic                    o_self_q,
   output logic [7:0]              o_lane_q
);
   wire logic [3:0] code_w = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
   wire logic       load_w = code_w == `CMD_LOAD_MODE;
   // ==========================================================
   // command decode
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_mode_q <= '0;
         o_ext_q <= '0;
         o_cmd_q <= `CMD_NOP;
         o_self_q <= 1'b0;
         o_lane_q <= 8'h00;
      end else begin
         if (!i_cs_n && code_w != `CMD_NOP) o_cmd_q <= code_w;
         if (code_w == `CMD_WRITE) o_lane_q <= ~i_dm;
         if (code_w == `CMD_REFRESH) o_self_q <= !i_cke;
         if (o_self_q && i_cke) begin
            o_self_q <= 1'b0;
            o_ext_q[`DLL_DIS_BIT] <= 1'b0;
         end
         if (load_w && i_ba == `BANK_BASE_MODE) o_mode_q <= i_addr & ~13'h0100;
         if (load_w && i_ba == `BANK_EXT_MODE) o_ext_q <= i_addr;
      end
   end
endmodule

// ===== verif/tb_ddr_cmd_ctrl.sv
/* Self-checking bench for the command controller with a memory model.
   Assumes design, package, header, model and checker compile first. */
`timescale 1ns/1ns
`include "ddr_cmd_cfg.svh"

module tb_ddr_cmd_ctrl;
   logic i_clk, i_rstn, i_req_valid, i_req_auto_pre, i_req_all_banks, i_dll_reset;
   logic i_dll_disable, i_drive_strength_select, o_req_ready, o_req_error, o_cs_n, o_ras_n;
   logic o_cas_n, o_we_n, o_cke, o_dll_enabled, o_read_allowed, o_self_refresh;
   logic o_dll_reset_pending, mself_q, e, rd_ok, lv;
   ddr_cmd_pkg::req_type      i_req_cmd, c, last;
   logic [1:0]                i_req_bank, o_ba;
   logic [`ADDR_W-1:0]        i_req_addr, o_addr, mode_q, ext_q;
   logic [`BURST_FIELD_W-1:0] i_burst_cfg;
   logic [7:0]                i_wr_mask, o_dm, lane_q, lm;
   logic [3:0]                mcmd_q;
   int                        fail_count, check_count, n;
   time                       t0;
   wire logic [3:0] cmd_w = {o_cs_n, o_ras_n, o_cas_n, o_we_n};

   ddr_cmd_ctrl u_ddr_cmd_ctrl (.*);
   ddr_mem_model u_ddr_mem_model (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(o_cs_n),
      .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_ba(o_ba), .i_addr(o_addr),
      .i_cke(o_cke), .i_dm(o_dm), .o_mode_q(mode_q), .o_ext_q(ext_q), .o_cmd_q(mcmd_q),
      .o_self_q(mself_q), .o_lane_q(lane_q));

   always #5 i_clk = ~i_clk;
   // ==========================================================
   // helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // hold request until taken or refused
   task automatic issue(input ddr_cmd_pkg::req_type r, input logic err);
      int k = 0;
      @(negedge i_clk);
      i_req_cmd = r;
      i_req_valid = 1'b1;
      #1;
      while (!o_req_ready && k < 20) begin
         @(negedge i_clk);
         #1;
         k++;
      end
      chk(o_req_ready, 1'b1);
      chk(o_req_error, err);
      @(negedge i_clk);
      i_req_valid = 1'b0;
   endtask
   function automatic logic [3:0] f_code(input ddr_cmd_pkg::req_type r);
      case (r)
         ddr_cmd_pkg::REQ_ACTIVE:    return `CMD_ACTIVE;
         ddr_cmd_pkg::REQ_READ:      return `CMD_READ;
         ddr_cmd_pkg::REQ_WRITE:     return `CMD_WRITE;
         ddr_cmd_pkg::REQ_PRECHARGE: return `CMD_PRECHARGE;
         ddr_cmd_pkg::REQ_REFRESH:   return `CMD_REFRESH;
         default:                    return `CMD_TERMINATE;
      endcase
   endfunction
   function automatic logic [`ADDR_W-1:0] f_addr(input ddr_cmd_pkg::req_type r);
      logic [`ADDR_W-1:0] a;
      a = (r == ddr_cmd_pkg::REQ_REFRESH) ? '0 : i_req_addr;
      if (r inside {ddr_cmd_pkg::REQ_READ, ddr_cmd_pkg::REQ_WRITE}) a[`AP_BIT] = i_req_auto_pre;
      if (r == ddr_cmd_pkg::REQ_PRECHARGE) a[`AP_BIT] = i_req_all_banks;
      return a;
   endfunction
   // ==========================================================
   // sequence; watchdog at 100 us allows about thirty times the expected run
   initial begin
      #100000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      {i_clk, i_rstn, i_req_valid, i_req_auto_pre, i_req_all_banks, i_dll_reset} = '0;
      {i_dll_disable, i_drive_strength_select, i_req_bank, i_req_addr} = '0;
      {i_burst_cfg, i_wr_mask, rd_ok, lv, lm, fail_count, check_count} = '0;
      i_req_cmd = ddr_cmd_pkg::REQ_NOP;
      last = ddr_cmd_pkg::REQ_NOP;
      void'($urandom(32'hB5E5));
      repeat (5) @(negedge i_clk);
      i_rstn = 1'b1;
      chk({cmd_w, o_cke, o_read_allowed, o_req_ready, o_dm}, {`CMD_DESELECT, 3'b101, 8'h00});
      issue(ddr_cmd_pkg::REQ_READ, 1'b1);
      chk(cmd_w, `CMD_DESELECT);
      i_dll_disable = 1'b1;
      i_drive_strength_select = 1'($urandom);
      issue(ddr_cmd_pkg::REQ_LOAD_EXT, 1'b0);
      chk({o_ba, o_addr}, {`BANK_EXT_MODE, 11'h000, i_drive_strength_select, 1'b1});
      @(negedge i_clk);
      chk({ext_q[1:0], o_dll_enabled}, {i_drive_strength_select, 2'b10});
      i_dll_disable = 1'b0;
      issue(ddr_cmd_pkg::REQ_LOAD_EXT, 1'b0);
      t0 = $time;
      chk({o_addr[0], o_dll_enabled, o_read_allowed}, 3'b010);
      i_burst_cfg = 7'($urandom);
      i_dll_reset = 1'b1;
      issue(ddr_cmd_pkg::REQ_LOAD_BASE, 1'b0);
      chk({o_ba, o_addr}, {`BANK_BASE_MODE, 6'h02, i_burst_cfg});
      @(negedge i_clk);
      chk({mode_q, o_dll_reset_pending}, {6'h00, i_burst_cfg, 1'b1});
      issue(ddr_cmd_pkg::REQ_LOAD_BASE, 1'b0);
      chk(o_addr, {6'h00, i_burst_cfg});
      @(negedge i_clk);
      chk(o_dll_reset_pending, 1'b0);
      n = 0;
      while (!o_read_allowed && n < 300) begin
         @(negedge i_clk);
         n++;
      end
      chk({o_read_allowed, ($time - t0) >= 64'h7C6}, 2'b11);
      for (int k = 0; k < 60; k++) begin
         {i_req_bank, i_req_auto_pre, i_req_all_banks} = 4'($urandom);
         i_req_addr = 13'($urandom);
         i_wr_mask = 8'($urandom);
         c = ddr_cmd_pkg::req_type'($urandom_range(6, 0));
         if (c == ddr_cmd_pkg::REQ_TERMINATE && last == c) c = ddr_cmd_pkg::REQ_NOP;
         e = (c == ddr_cmd_pkg::REQ_TERMINATE) && !rd_ok;
         issue(c, e);
         chk(o_dm, i_wr_mask);
         if (lv) chk({mcmd_q, lane_q}, {f_code(last), lm});
         lv = !e && c != ddr_cmd_pkg::REQ_NOP;
         if (e) chk(cmd_w, `CMD_DESELECT);
         else if (!lv) chk(o_cs_n | (cmd_w == `CMD_NOP), 1'b1);
         else chk(cmd_w, f_code(c));
         if (lv && c != ddr_cmd_pkg::REQ_TERMINATE) chk(o_addr, f_addr(c));
         if (c inside {[ddr_cmd_pkg::REQ_ACTIVE : ddr_cmd_pkg::REQ_WRITE]})
            chk(o_ba, i_req_bank);
         if (c == ddr_cmd_pkg::REQ_WRITE) lm = ~i_wr_mask;
         // precharge and terminate also end a read burst
         if (c inside {ddr_cmd_pkg::REQ_READ, ddr_cmd_pkg::REQ_WRITE,
                       ddr_cmd_pkg::REQ_TERMINATE, ddr_cmd_pkg::REQ_PRECHARGE})
            rd_ok = !i_req_auto_pre && c == ddr_cmd_pkg::REQ_READ;
         last = c;
      end
      issue(ddr_cmd_pkg::REQ_SELF_EXIT, 1'b1);
      issue(ddr_cmd_pkg::REQ_SELF_ENTER, 1'b0);
      chk({cmd_w, o_cke, o_self_refresh}, {`CMD_REFRESH, 2'b01});
      issue(ddr_cmd_pkg::REQ_READ, 1'b1);
      chk(mself_q, 1'b1);
      issue(ddr_cmd_pkg::REQ_SELF_EXIT, 1'b0);
      chk({o_cke, o_self_refresh, o_read_allowed}, 3'b100);
      @(negedge i_clk);
      chk({mself_q, ext_q[`DLL_DIS_BIT]}, 2'b00);
      report_and_stop();
   end
endmodule

bind ddr_cmd_ctrl ddr_cmd_ctrl_assertions u_ddr_cmd_ctrl_assertions (.*);
